//--- core/ssse_engine.sv
// Programmable supply sequencing state engine with APB register access.
`timescale 1ns/100ps
`default_nettype none

module ssse_engine #(
  parameter int unsigned BOOT_CYCLES = ssse_pkg::BOOT_CYCLES
) (
  input wire logic pclk,                                  // System clock, 50 MHz.
  input wire logic presetn,                               // Asynchronous reset, active low.
  input wire logic [ssse_pkg::APB_AW-1:0] paddr,          // APB byte address.
  input wire logic psel,                                  // APB select.
  input wire logic penable,                               // APB enable.
  input wire logic pwrite,                                // APB direction, high for write.
  input wire logic [31:0] pwdata,                         // APB write data.
  output logic [31:0] prdata,                             // APB read data.
  output logic pready,                                    // APB ready.
  output logic pslverr,                                   // APB error on unmapped address.
  input wire logic [ssse_pkg::NUM_IN-1:0] detector_ok,    // Filtered input status, high is ok.
  input wire logic [ssse_pkg::WARN_W-1:0] warn_src,       // Warning sources, high is warning.
  input wire logic cfg_done,                              // Configuration download complete.
  output logic [ssse_pkg::NUM_OUT-1:0] driver_output      // Driver output levels.
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Converts a delay field into a count of 10 us ticks.
  function automatic logic [15:0] delay_ticks(input ssse_pkg::ssse_delay_t d);
    logic [15:0] mult;
    mult = ssse_pkg::MULT_10US;
    unique case (d.unit)
      ssse_pkg::UNIT_10US: mult = ssse_pkg::MULT_10US;
      ssse_pkg::UNIT_100US: mult = ssse_pkg::MULT_100US;
      ssse_pkg::UNIT_1MS: mult = ssse_pkg::MULT_1MS;
      ssse_pkg::UNIT_4MS: mult = ssse_pkg::MULT_4MS;
    endcase
    return 16'(16'(d.count) * mult);
  endfunction

  // Saturating increment of a tick counter.
  function automatic logic [15:0] tick_inc(input logic [15:0] v);
    return (v == ssse_pkg::TICKS_MAX) ? v : 16'(v + 16'h0001);
  endfunction

  // ----------------------------------------------------------------
  // State and memory
  // ----------------------------------------------------------------
  ssse_pkg::ssse_state_t s;
  ssse_pkg::ssse_state_t next_s;
  ssse_pkg::ssse_def_t rd_data;

  ssse_state_mem u_mem (
    .pclk(pclk),
    .wr(s.wr),
    .rd_addr(s.rd_addr),
    .rd_data(rd_data)
  );

  // Outputs come straight from the state register.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign driver_output = s.drv;

  // ----------------------------------------------------------------
  // Combinational decode of the current state
  // ----------------------------------------------------------------
  logic warn_any;
  logic tick;
  logic apb_setup;
  logic apb_write;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic seq_cond;
  logic mon_fault;
  logic seq_exit;
  logic to_exit;
  logic [15:0] seq_limit;
  logic [15:0] to_limit;
  logic [ssse_pkg::NUM_IN-1:0] fault_clr;
  logic [ssse_pkg::NUM_IN-1:0] fault_set;
  logic jump_req;

  // All warnings merge into a single level.
  assign warn_any = |warn_src; // [RULE_09]
  assign tick = (s.pre == ssse_pkg::TICK_LAST);
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && s.pready && pwrite;
  assign seq_limit = delay_ticks(s.def.seq_time); // [RULE_12]
  assign to_limit = delay_ticks(s.def.timeout_time); // [RULE_15]

  // Address decode and read data for the setup cycle.
  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ssse_pkg::ADDR_CTRL: rd_mux = {31'h0000_0000, s.jump_pend};
      ssse_pkg::ADDR_STATUS: rd_mux = {11'h000, warn_any, s.fsm, s.drv, s.cur};
      ssse_pkg::ADDR_FAULT_LO: rd_mux = {24'h00_0000, s.fault[7:0]}; // [RULE_17]
      ssse_pkg::ADDR_FAULT_HI: rd_mux = {30'h0000_0000, s.fault[9:8]}; // [RULE_17]
      ssse_pkg::ADDR_MEM_ADDR: rd_mux = {26'h000_0000, s.mem_addr};
      ssse_pkg::ADDR_MEM_LO: rd_mux = s.mem_lo;
      ssse_pkg::ADDR_MEM_HI: rd_mux = 32'h0000_0000;
      default: addr_hit = 1'b0;
    endcase
  end

  // Sequence condition: a filtered input or the warning at its programmed level.
  always_comb begin
    seq_cond = 1'b0;
    if (s.def.seq_sel < 4'(ssse_pkg::NUM_IN)) begin
      seq_cond = (detector_ok[s.def.seq_sel] == s.def.seq_level); // [RULE_08] [RULE_11]
    end else if (s.def.seq_sel == ssse_pkg::SEL_WARN) begin
      seq_cond = (warn_any == s.def.seq_level); // [RULE_09]
    end
  end

  // Monitor is an undelayed wide OR over selected inputs that are not ok.
  assign mon_fault = (|(s.def.mon_mask & ~detector_ok))
                     || (s.def.mon_warn && warn_any); // [RULE_13] [RULE_14] [RULE_02]

  // Sequence exit after its delay, or at once on a pending jump.
  assign seq_exit = s.jump_pend
                    || (s.seq_met && (s.seq_ticks >= seq_limit)); // [RULE_10] [RULE_12]

  // Timeout exit if still waiting at the deadline; zero time disables the deadline.
  assign to_exit = (!s.seq_met && (to_limit != 16'h0000) && (s.to_ticks >= to_limit))
                   || (s.def.timeout_on_warn && warn_any); // [RULE_15] [RULE_09]

  // Bus-side events.
  assign jump_req = apb_write && (paddr == ssse_pkg::ADDR_CTRL) && pwdata[ssse_pkg::CTRL_JUMP_BIT];
  assign fault_clr = {(apb_write && (paddr == ssse_pkg::ADDR_FAULT_HI)) ?
                        pwdata[ssse_pkg::FAULT_HI_W-1:0] : 2'h0,
                      (apb_write && (paddr == ssse_pkg::ADDR_FAULT_LO)) ?
                        pwdata[ssse_pkg::FAULT_LO_W-1:0] : 8'h00};
  // Faults record only while the current definition enables latching.
  assign fault_set = (s.fsm != ssse_pkg::ST_BOOT && s.def.latch_en) ?
                     ~detector_ok : '0; // [RULE_18]

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Builds the whole next state: bus slave, fault latch and engine sequencing.
  always_comb begin
    next_s = s;
    next_s.wr.we = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    // APB answers in the first access cycle with registered data.
    if (apb_setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = pwrite ? 32'h0000_0000 : rd_mux;
      next_s.pslverr = !addr_hit;
    end

    // Register writes take effect at the completing edge.
    if (apb_write && (paddr == ssse_pkg::ADDR_MEM_ADDR)) begin
      next_s.mem_addr = pwdata[ssse_pkg::STATE_W-1:0];
    end
    if (apb_write && (paddr == ssse_pkg::ADDR_MEM_LO)) begin
      next_s.mem_lo = pwdata;
    end
    // Writing the upper half commits the 64-bit definition word.
    if (apb_write && (paddr == ssse_pkg::ADDR_MEM_HI)) begin
      next_s.wr.we = 1'b1; // [RULE_19]
      next_s.wr.addr = s.mem_addr;
      next_s.wr.data = ssse_pkg::ssse_def_t'({pwdata, s.mem_lo});
    end

    // Fault latch; a new fault wins over a clear in the same cycle.
    next_s.fault = (s.fault & ~fault_clr) | fault_set; // [RULE_16]

    // Jump request is held until the sequence exit consumes it.
    if (jump_req) begin
      next_s.jump_pend = 1'b1; // [RULE_10]
    end

    unique case (s.fsm)
      // Wait for the configuration download, then the start delay.
      ssse_pkg::ST_BOOT: begin
        if (cfg_done) begin
          next_s.boot_cnt = 16'(s.boot_cnt + 16'h0001);
          if (s.boot_cnt == 16'(BOOT_CYCLES - 1)) begin
            next_s.fsm = ssse_pkg::ST_LOAD; // [RULE_20]
            next_s.cur = ssse_pkg::FIRST_STATE;
            next_s.rd_addr = ssse_pkg::FIRST_STATE;
          end
        end else begin
          next_s.boot_cnt = 16'h0000;
        end
      end
      // Memory registers the addressed definition.
      ssse_pkg::ST_LOAD: begin
        next_s.fsm = ssse_pkg::ST_FETCH; // [RULE_07]
      end
      // Take the new definition, apply outputs, restart timers.
      ssse_pkg::ST_FETCH: begin
        next_s.def = rd_data; // [RULE_05]
        next_s.drv = rd_data.levels; // [RULE_06]
        next_s.pre = 9'h000; // [RULE_22]
        next_s.seq_ticks = 16'h0000; // [RULE_22]
        next_s.to_ticks = 16'h0000; // [RULE_22]
        next_s.seq_met = 1'b0;
        next_s.fsm = ssse_pkg::ST_RUN;
      end
      // Hold outputs, run timers and watch the three exits.
      ssse_pkg::ST_RUN: begin
        next_s.pre = tick ? 9'h000 : 9'(s.pre + 9'h001);
        if (tick) begin
          next_s.to_ticks = tick_inc(s.to_ticks);
          if (s.seq_met) begin
            next_s.seq_ticks = tick_inc(s.seq_ticks);
          end
        end
        // Sequence step done once the condition is seen.
        if (seq_cond) begin
          next_s.seq_met = 1'b1; // [RULE_11]
        end
        // Fixed priority: monitor, then sequence (with jump), then timeout.
        if (mon_fault) begin
          next_s.cur = s.def.mon_next; // [RULE_21] [RULE_04] [RULE_14]
          next_s.rd_addr = s.def.mon_next; // [RULE_03]
          next_s.fsm = ssse_pkg::ST_LOAD;
        end else if (seq_exit) begin
          next_s.cur = s.def.seq_next; // [RULE_21] [RULE_04]
          next_s.rd_addr = s.def.seq_next; // [RULE_03]
          next_s.fsm = ssse_pkg::ST_LOAD;
          next_s.jump_pend = jump_req; // [RULE_10]
        end else if (to_exit) begin
          next_s.cur = s.def.timeout_next; // [RULE_21] [RULE_04]
          next_s.rd_addr = s.def.timeout_next; // [RULE_03]
          next_s.fsm = ssse_pkg::ST_LOAD;
        end
      end
      default: begin
        next_s.fsm = ssse_pkg::ST_BOOT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Registers the whole block state; reset loads constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.fsm <= ssse_pkg::ST_BOOT;
    end else begin
      s <= next_s;
    end
  end

endmodule // ssse_engine

`default_nettype wire

//--- core/ssse_state_mem.sv
// Store of 64-bit state definitions with a registered read port.
`timescale 1ns/100ps
`default_nettype none

module ssse_state_mem (
  input wire logic pclk,                                // System clock.
  input wire ssse_pkg::ssse_mem_wr_t wr,                // Write strobe, slot and word.
  input wire logic [ssse_pkg::STATE_W-1:0] rd_addr,     // Slot to read.
  output ssse_pkg::ssse_def_t rd_data                   // Registered read word.
);

  ssse_pkg::ssse_def_t mem [0:(1 << ssse_pkg::STATE_W) - 1];

  // Write port; the reserved slot is never written.
  always_ff @(posedge pclk) begin
    if (wr.we && (wr.addr != ssse_pkg::RESERVED_SLOT)) begin // [RULE_19]
      mem[wr.addr] <= wr.data;
    end
  end

  // Read port, data valid one edge after the address.
  always_ff @(posedge pclk) begin
    rd_data <= mem[rd_addr]; // [RULE_01]
  end

endmodule // ssse_state_mem

`default_nettype wire

//--- include/ssse_pkg.sv
// Package of constants and types for the supply sequencing state engine.
//
// Overview of operation
// RULE_01: Up to 63 programmable states, each with its own stored definition.
// RULE_02: Every state observes status of all ten monitored supply and dual inputs.
// RULE_03: Next-state fields are six bits wide, so any state is reachable.
// RULE_04: Each state has sequence, monitor and timeout exits with separate targets.
// RULE_05: Sequence delay and timeout are independent, reloaded per state, up to 400 ms.
// RULE_06: Definition fixes all ten driver outputs; they hold while the state holds.
// RULE_07: A state change including definition load completes well under 20 us.
// RULE_08: Engine evaluates filtered fault detector outputs, never raw pin levels.
// RULE_09: All warning sources OR into one signal usable by all three exits.
// RULE_10: Bus jump command forces an advance via the sequence and timeout exits; the code advances via the sequence exit only.
// RULE_11: Sequence exit is taken when the selected input reaches its programmed level.
// RULE_12: Sequence exit can be delayed by a programmable time of up to 400 ms.
// RULE_13: Monitor exit is a wide OR over selected inputs leaving expected condition.
// RULE_14: Monitor exit has no delay; only the definition load adds latency.
// RULE_15: Timeout exit fires when the awaited condition misses a programmable deadline.
// RULE_16: Fault latch in two registers, one bit per input, set by that input's fault.
// RULE_17: Host can read both fault latch registers over the bus.
// RULE_18: Each definition enables fault latching; when disabled, faults are not recorded.
// RULE_19: Definitions are 64-bit words in a 64-slot store, the last slot reserved.
// RULE_20: First definition loads 0.5 ms after configuration download completes.
// RULE_21: Simultaneous exits resolve by fixed priority: monitor, sequence, timeout.
// RULE_22: Entering a state restarts the sequence delay and timeout timers from zero.
package ssse_pkg;

  // ----------------------------------------------------------------
  // Sizes and clock timing
  // ----------------------------------------------------------------
  localparam int unsigned NUM_IN = 10;
  localparam int unsigned NUM_OUT = 10;
  localparam int unsigned WARN_W = 11;
  localparam int unsigned STATE_W = 6;
  localparam int unsigned APB_AW = 8;
  localparam logic [STATE_W-1:0] FIRST_STATE = 6'h00;
  localparam logic [STATE_W-1:0] RESERVED_SLOT = 6'h3F;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BOOT_DELAY_NS = 500000;
  localparam int unsigned BOOT_CYCLES = (BOOT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_NS = 10000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [8:0] TICK_LAST = 9'(TICK_CYCLES - 1);
  localparam logic [15:0] TICKS_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Delay field encoding: count times a unit of 1, 10, 100 or 400 ticks
  // ----------------------------------------------------------------
  localparam logic [1:0] UNIT_10US = 2'h0;
  localparam logic [1:0] UNIT_100US = 2'h1;
  localparam logic [1:0] UNIT_1MS = 2'h2;
  localparam logic [1:0] UNIT_4MS = 2'h3;
  localparam logic [15:0] MULT_10US = 16'h0001;
  localparam logic [15:0] MULT_100US = 16'h000A;
  localparam logic [15:0] MULT_1MS = 16'h0064;
  localparam logic [15:0] MULT_4MS = 16'h0190;
  localparam logic [3:0] SEL_WARN = 4'hA;

  // ----------------------------------------------------------------
  // Register byte addresses and fields
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_FAULT_LO = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_FAULT_HI = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_MEM_ADDR = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_MEM_LO = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_MEM_HI = 8'h18;
  localparam int unsigned CTRL_JUMP_BIT = 0;
  localparam int unsigned FAULT_LO_W = 8;
  localparam int unsigned FAULT_HI_W = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] unit;
    logic [6:0] count;
  } ssse_delay_t;

  typedef struct packed {
    ssse_delay_t timeout_time;
    ssse_delay_t seq_time;
    logic timeout_on_warn;
    logic latch_en;
    logic mon_warn;
    logic [NUM_IN-1:0] mon_mask;
    logic seq_level;
    logic [3:0] seq_sel;
    logic [STATE_W-1:0] timeout_next;
    logic [STATE_W-1:0] mon_next;
    logic [STATE_W-1:0] seq_next;
    logic [NUM_OUT-1:0] levels;
  } ssse_def_t;

  typedef struct packed {
    logic we;
    logic [STATE_W-1:0] addr;
    ssse_def_t data;
  } ssse_mem_wr_t;

  typedef enum logic [3:0] {
    ST_BOOT = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_RUN = 4'b1000
  } ssse_fsm_t;

  typedef struct packed {
    ssse_fsm_t fsm;
    logic [STATE_W-1:0] cur;
    ssse_def_t def;
    logic [8:0] pre;
    logic [15:0] seq_ticks;
    logic [15:0] to_ticks;
    logic seq_met;
    logic jump_pend;
    logic [15:0] boot_cnt;
    logic [NUM_IN-1:0] fault;
    logic [STATE_W-1:0] mem_addr;
    logic [31:0] mem_lo;
    ssse_mem_wr_t wr;
    logic [STATE_W-1:0] rd_addr;
    logic [NUM_OUT-1:0] drv;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ssse_state_t;

endpackage

//--- sim/ssse_engine_monitor.sv
// Checker of bus answers and driver output timing at the engine ports.
`timescale 1ns/100ps
`default_nettype none
module ssse_engine_monitor #(
  parameter int unsigned BOOT_CYCLES = 8
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic [7:0] paddr, // Address.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic [9:0] detector_ok, // Input status.
  input wire logic [10:0] warn_src, // Warnings.
  input wire logic cfg_done, // Download done.
  input wire logic [9:0] driver_output // Driver levels.
);
  logic [15:0] boot_cnt;
  logic booted;
  logic mapped;
  // Decodes the word addresses that carry a register.
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h18);
  // Marks that the download has stood long enough for the first load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt <= 16'h0000;
      booted <= 1'b0;
    end else begin
      boot_cnt <= cfg_done ? boot_cnt + 16'h0001 : 16'h0000;
      booted <= booted | (boot_cnt >= 16'(BOOT_CYCLES));
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("No answer after setup.");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("Answer without setup.");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("Ready held too long.");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("Unmapped access not refused.");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("Mapped access refused.");
  a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("Refusal carries data.");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("Write answer carries data.");
  a_out_spacing: assert property ($changed(driver_output)
    |=> $stable(driver_output) [*2])
    else $error("Outputs changed inside a load.");
  a_boot_quiet: assert property (!booted |-> driver_output == 10'h000)
    else $error("Outputs driven before boot delay.");
  a_status_warn: assert property (pready && !pwrite && paddr == 8'h04
    |-> prdata[20] == $past(|warn_src))
    else $error("Warning status bit wrong.");
  c_write: cover property (pready && pwrite);
  c_refuse: cover property (pslverr);
  c_change: cover property ($changed(driver_output));
endmodule // ssse_engine_monitor
bind ssse_engine ssse_engine_monitor #(.BOOT_CYCLES(BOOT_CYCLES)) mon_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .detector_ok(detector_ok), .warn_src(warn_src), .cfg_done(cfg_done),
  .driver_output(driver_output)
);
`default_nettype wire

//--- sim/ssse_supply_model.sv
// Model of the supplies and filtered fault detectors behind the engine.
`timescale 1ns/100ps
`default_nettype none
module ssse_supply_model #(
  parameter int unsigned RISE = 20
) (
  input wire logic pclk, // Clock.
  input wire logic [9:0] driver_output, // Supply enables.
  input wire logic [9:0] fail, // Faults forced by the bench.
  output logic [9:0] detector_ok // Filtered status, high is ok.
);
  logic [7:0] cnt [1:3] = '{8'h00, 8'h00, 8'h00};
  // Supplies one to three settle RISE cycles after their enable rises.
  always @(posedge pclk) begin
    for (int i = 1; i <= 3; i++) begin
      if (!driver_output[i-1]) cnt[i] <= 8'h00;
      else if (cnt[i] < 8'(RISE)) cnt[i] <= cnt[i] + 8'h01;
    end
  end
  // Status is the settled level, not the raw enable; other inputs stay good.
  assign detector_ok = {6'h3F, cnt[3] == 8'(RISE), cnt[2] == 8'(RISE),
                       cnt[1] == 8'(RISE), 1'b1} & ~fail;
endmodule // ssse_supply_model
`default_nettype wire

//--- sim/test_supply_sequencing_state_engine.sv
// Self-checking bench of the sequencing engine through its bus and inputs.
`timescale 1ns/100ps
`default_nettype none
module test_supply_sequencing_state_engine;
  localparam int unsigned BOOT = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] detector_ok;
  logic [10:0] warn_src = 11'h000;
  logic cfg_done = 1'b0;
  logic [9:0] fail = 10'h000;
  logic [9:0] driver_output;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  // Free-running 50 MHz clock.
  always #10 pclk = ~pclk;
  ssse_engine #(.BOOT_CYCLES(BOOT)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .detector_ok(detector_ok), .warn_src(warn_src),
    .cfg_done(cfg_done), .driver_output(driver_output));
  ssse_supply_model #(.RISE(20)) sup_u (.pclk(pclk), .driver_output(driver_output),
    .fail(fail), .detector_ok(detector_ok));
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer; the request holds until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_out(input logic [9:0] exp, input int lim);
    int n;
    n = 0;
    while (driver_output !== exp && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({22'h0, driver_output}, {22'h0, exp});
  endtask
  task automatic hold_out(input logic [9:0] exp, input int len);
    int bad;
    bad = 0;
    repeat (len) begin
      @(posedge pclk);
      if (driver_output !== exp) bad++;
    end
    chk(32'(bad), 32'h0);
  endtask
  function automatic ssse_pkg::ssse_def_t df(input logic [9:0] lv, input logic [5:0] sn,
    input logic [5:0] mn, input logic [5:0] tn, input logic [3:0] sel, input logic sl,
    input logic [9:0] mm, input logic le, input logic [8:0] st, input logic [8:0] tt);
    df = '{timeout_time: tt, seq_time: st, timeout_on_warn: 1'b0, latch_en: le,
      mon_warn: 1'b0, mon_mask: mm, seq_level: sl, seq_sel: sel, timeout_next: tn,
      mon_next: mn, seq_next: sn, levels: lv};
  endfunction
  function automatic logic [31:0] stat(input logic [9:0] dv, input logic [5:0] st);
    stat = {12'h000, 4'h8, dv, st};
  endfunction
  task automatic prog(input logic [5:0] s, input ssse_pkg::ssse_def_t d);
    wr(ssse_pkg::ADDR_MEM_ADDR, {26'h0, s});
    wr(ssse_pkg::ADDR_MEM_LO, d[31:0]);
    wr(ssse_pkg::ADDR_MEM_HI, d[63:32]);
  endtask
  // Programs the store, then checks the boot delay and first state.
  task automatic t_boot;
    rdc(ssse_pkg::ADDR_STATUS, 32'h00010000);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    prog(6'h00, df(10'h001, 6'h01, 6'h03, 6'h02, 4'h1, 1'b1, 10'h001, 1'b0, 9'h000, 9'h000));
    prog(6'h01, df(10'h003, 6'h04, 6'h03, 6'h00, 4'hA, 1'b1, 10'h003, 1'b0, 9'h003, 9'h000));
    prog(6'h02, df(10'h200, 6'h00, 6'h00, 6'h05, 4'h8, 1'b0, 10'h000, 1'b0, 9'h000, 9'h002));
    prog(6'h03, df(10'h100, 6'h02, 6'h00, 6'h00, 4'hF, 1'b0, 10'h000, 1'b0, 9'h000, 9'h000));
    prog(6'h04, df(10'h007, 6'h3E, 6'h00, 6'h00, 4'hF, 1'b0, 10'h000, 1'b0, 9'h000, 9'h000));
    prog(6'h05, df(10'h155, 6'h00, 6'h03, 6'h00, 4'h9, 1'b0, 10'h200, 1'b0, 9'h000, 9'h000));
    prog(6'h3E, df(10'h3FF, 6'h00, 6'h03, 6'h00, 4'hF, 1'b0, 10'h200, 1'b1, 9'h000, 9'h000));
    cfg_done <= 1'b1;
    hold_out(10'h000, BOOT);
    wait_out(10'h001, 10);
    rdc(ssse_pkg::ADDR_STATUS, stat(10'h001, 6'h00));
  endtask
  // The supply settles and the sequence exit moves on at once.
  task automatic t_seq;
    wait_out(10'h003, 1000);
    rdc(ssse_pkg::ADDR_STATUS, stat(10'h003, 6'h01));
  endtask
  // A warning gates a delayed sequence exit of three ticks.
  task automatic t_delay;
    warn_src <= 11'h020;
    rdc(ssse_pkg::ADDR_STATUS, stat(10'h003, 6'h01) | 32'h0010_0000);
    hold_out(10'h003, 990);
    wait_out(10'h007, 540);
    warn_src <= 11'h000;
  endtask
  // A held state with no exits is left only by the bus jump.
  task automatic t_jump;
    hold_out(10'h007, 50);
    wr(ssse_pkg::ADDR_CTRL, 32'h1);
    wait_out(10'h3FF, 10);
    rdc(ssse_pkg::ADDR_STATUS, stat(10'h3FF, 6'h3E));
    rdc(ssse_pkg::ADDR_FAULT_LO, 32'h0);
    rdc(ssse_pkg::ADDR_FAULT_HI, 32'h0);
  endtask
  // A monitored input fails; the exit is quick and the fault is latched.
  task automatic t_mon;
    fail <= 10'h200;
    wait_out(10'h100, 8);
    fail <= 10'h000;
    rdc(ssse_pkg::ADDR_FAULT_HI, 32'h2);
    rdc(ssse_pkg::ADDR_FAULT_LO, 32'h0);
    wr(ssse_pkg::ADDR_FAULT_HI, 32'h2);
    rdc(ssse_pkg::ADDR_FAULT_HI, 32'h0);
  endtask
  // The awaited level never comes, so the timeout exit fires.
  task automatic t_time;
    wr(ssse_pkg::ADDR_CTRL, 32'h1);
    wait_out(10'h200, 10);
    hold_out(10'h200, 900);
    wait_out(10'h155, 200);
  endtask
  // A pending jump meets a monitor fault; the monitor wins, the jump is taken next.
  task automatic t_prio;
    wr(ssse_pkg::ADDR_CTRL, 32'h1);
    fail <= 10'h200;
    wait_out(10'h100, 8);
    fail <= 10'h000;
    wait_out(10'h200, 10);
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_boot;
    t_seq;
    t_delay;
    t_jump;
    t_mon;
    t_time;
    t_prio;
    wrap_up;
  end
endmodule // test_supply_sequencing_state_engine
`default_nettype wire
